// [hw/cis_exec_unit.sv]
// Instruction execution unit of an 8-bit core with a classic Wishbone register slave
//
// How it works
// RULE1: add-with-carry sums A, operand, carry; sets flags
// RULE2: subtract-with-carry: A plus complemented operand plus carry
// RULE3: and_skip_zero skips when A AND imm zero
// RULE4: compare_greater runs next only if A greater
// RULE5: compare_equal: memory vs imm, or A vs operand
// RULE6: compare_unequal runs next only when values differ
// RULE7: pointer_nibble_compare tests low nibble of B
// RULE8: decrement_skip_zero writes back, skips on zero
// RULE9: bit_set / bit_clear write chosen memory bit
// RULE10: bit_test runs next only if bit set
// RULE11: clear_trap_pending clears trap flag only
// RULE12: pointer loads, exchanges, stores step pointer after
// RULE13: table_load reads program memory at high PC, A
// RULE14: decimal_adjust corrects A using carry, half_carry
// RULE15: rotates go through carry; left copies A0
// RULE16: push writes then decrements; pop increments first
// RULE17: vector_dispatch loads PC from two vector bytes
// RULE18: long_jump replaces whole 15-bit program counter
// RULE19: relative_jump adds -31..+32, never one
// RULE20: software_trap pushes PC, SP minus two, PC 0FF
// RULE21: subroutine_exit raises SP two, restores PC
// RULE22: interrupt_exit restores PC and sets irq enable
// RULE23: skipped instruction is no-op, one cycle per byte
// RULE24: other ops keep flags; no-op only advances PC
//
// The Wishbone register port and the address map were chosen for this implementation.
`include "cis_cfg.svh"

module cis_exec_unit #(
  parameter int DMEM_AW = 8,
  parameter int PMEM_AW = 8
) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  output logic [31:0] wb_dat_out,
  output logic wb_ack_out,
  output logic global_irq_enable_out,
  output logic trap_pending_out
);
  import cis_pkg::*;

  ////////////////////////////////////////////////////////////////////////////////
  // State

  logic ack_q;
  logic [31:0] rd_q;
  cis_state_t state_q;
  logic [1:0] cnt_q;
  cis_cmd_t cmd_q;
  logic [7:0] a_q;
  logic c_q;
  logic half_carry_q;
  logic gie_q;
  logic pend_q;
  logic skip_q;
  logic err_q;
  logic [14:0] pc_q;
  logic [7:0] stack_pointer_q;
  logic [7:0] b_q;
  logic [7:0] x_q;
  logic [7:0] daddr_q;
  logic [14:0] paddr_q;
  logic [14:0] vec_q;
  logic [7:0] dmem_q [2**DMEM_AW];
  logic [7:0] pmem_q [2**PMEM_AW];

  ////////////////////////////////////////////////////////////////////////////////
  // Wishbone slave: ack one cycle after the request, write lands at the acked edge

  logic req;
  logic wr;
  logic [31:0] wdat;
  logic [31:0] rdat;

  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] sel);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr[7:2] == off[7:2];
  endfunction

  assign req = wb_cyc_in & wb_stb_in;
  assign wr = req & wb_we_in & ack_q;
  assign wdat = wb_dat_in;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      ack_q <= 1'b0;
      rd_q <= 32'h0000_0000;
    end else begin
      ack_q <= req & ~ack_q;
      if (req & ~ack_q) begin
        rd_q <= rdat;
      end
    end
  end

  assign wb_ack_out = ack_q;
  assign wb_dat_out = rd_q;
  assign global_irq_enable_out = gie_q;
  assign trap_pending_out = pend_q;

  logic [31:0] flags_word;

  always_comb begin
    flags_word = 32'h0000_0000;
    flags_word[`CIS_FB_CARRY] = c_q;
    flags_word[`CIS_FB_HALF] = half_carry_q;
    flags_word[`CIS_FB_GIE] = gie_q;
    flags_word[`CIS_FB_PEND] = pend_q;
    flags_word[`CIS_FB_SKIP] = skip_q;
    flags_word[`CIS_FB_BUSY] = state_q != ST_IDLE;
    flags_word[`CIS_FB_ERR] = err_q;
    rdat = 32'h0000_0000;
    if (hit(wb_adr_in, `CIS_OFF_CMD)) begin
      rdat = cmd_q;
    end else if (hit(wb_adr_in, `CIS_OFF_ACC)) begin
      rdat = {24'h00_0000, a_q};
    end else if (hit(wb_adr_in, `CIS_OFF_FLAGS)) begin
      rdat = flags_word;
    end else if (hit(wb_adr_in, `CIS_OFF_PTRS)) begin
      rdat = {8'h00, stack_pointer_q, x_q, b_q};
    end else if (hit(wb_adr_in, `CIS_OFF_PC)) begin
      rdat = {17'h0_0000, pc_q};
    end else if (hit(wb_adr_in, `CIS_OFF_DADDR)) begin
      rdat = {24'h00_0000, daddr_q};
    end else if (hit(wb_adr_in, `CIS_OFF_DDATA)) begin
      rdat = {24'h00_0000, dmem_q[daddr_q[DMEM_AW-1:0]]};
    end else if (hit(wb_adr_in, `CIS_OFF_PADDR)) begin
      rdat = {17'h0_0000, paddr_q};
    end else if (hit(wb_adr_in, `CIS_OFF_PDATA)) begin
      rdat = {24'h00_0000, pmem_q[paddr_q[PMEM_AW-1:0]]};
    end else if (hit(wb_adr_in, `CIS_OFF_VEC)) begin
      rdat = {17'h0_0000, vec_q};
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic cmd_wr;
  logic fire;
  logic skip_fire;

  assign cmd_wr = wr & hit(wb_adr_in, `CIS_OFF_CMD);
  assign fire = (state_q == ST_EXEC) & ~skip_q;
  assign skip_fire = (state_q == ST_EXEC) & skip_q;

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_q <= ST_IDLE;
      cnt_q <= 2'b00;
      cmd_q <= '0;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (cmd_wr) begin
            cmd_q <= lane_merge(cmd_q, wdat, wb_sel_in);
            state_q <= ST_EXEC;
          end
        end
        ST_EXEC: begin
          // A skipped command holds the unit one cycle per opcode byte
          if (skip_q && cmd_q.nbytes > 2'd1) begin // [RULE23]
            state_q <= ST_SKIP;
            cnt_q <= cmd_q.nbytes - 2'd2;
          end else begin
            state_q <= ST_IDLE;
          end
        end
        ST_SKIP: begin
          if (cnt_q == 2'b00) begin
            state_q <= ST_IDLE;
          end else begin
            cnt_q <= cnt_q - 2'b01;
          end
        end
        default: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Datapath

  logic [7:0] oaddr;
  logic [7:0] mem_op;
  logic [7:0] opnd;
  logic [7:0] am;
  logic ci;
  logic [4:0] lo5;
  logic [4:0] hi5;
  logic [7:0] reg_addr;
  logic [7:0] dec_v;
  logic [7:0] bit_mask;
  logic [7:0] sp_up1;
  logic [7:0] sp_up2;
  logic [14:0] pc_seq;
  logic [7:0] tbl_v;
  logic [7:0] vec_hi;
  logic [7:0] vec_lo;
  logic jp_ok;

  logic [7:0] a_d;
  logic c_d;
  logic half_carry_d;
  logic gie_d;
  logic pend_d;
  logic skip_d;
  logic err_d;
  logic [14:0] pc_d;
  logic [7:0] sp_d;
  logic [7:0] b_d;
  logic [7:0] x_d;
  cis_mwr_t mw0;
  cis_mwr_t mw1;

  always_comb begin
    case (cmd_q.src)
      SRC_PTR_B: oaddr = b_q;
      SRC_PTR_X: oaddr = x_q;
      default: oaddr = cmd_q.addr;
    endcase
  end

  assign mem_op = dmem_q[oaddr[DMEM_AW-1:0]];
  assign opnd = (cmd_q.src == SRC_IMM) ? cmd_q.imm : mem_op;
  // Subtract adds the complement, so carry set means no borrow
  assign am = (cmd_q.op == OP_SUBTRACT_WITH_CARRY) ? ~opnd : opnd;
  assign ci = (cmd_q.op == OP_ADD) ? 1'b0 : c_q;
  assign lo5 = {1'b0, a_q[3:0]} + {1'b0, am[3:0]} + {4'h0, ci};
  assign hi5 = {1'b0, a_q[7:4]} + {1'b0, am[7:4]} + {4'h0, lo5[4]};
  assign reg_addr = {`CIS_REG_PAGE, cmd_q.addr[3:0]};
  assign dec_v = dmem_q[reg_addr[DMEM_AW-1:0]] - 8'h01;
  assign bit_mask = 8'h01 << cmd_q.bit_num;
  assign sp_up1 = stack_pointer_q + 8'h01;
  assign sp_up2 = stack_pointer_q + 8'h02;
  assign pc_seq = pc_q + {13'h0000, cmd_q.nbytes};
  assign tbl_v = pmem_q[PMEM_AW'({pc_q[14:8], a_q})];
  assign vec_hi = pmem_q[vec_q[PMEM_AW-1:0]];
  assign vec_lo = pmem_q[PMEM_AW'(vec_q + 15'h0001)];
  assign jp_ok = ($signed(cmd_q.imm) >= $signed(`CIS_JP_MIN)) &&
                 ($signed(cmd_q.imm) <= $signed(`CIS_JP_MAX)) &&
                 (cmd_q.imm != `CIS_JP_BAD);

  always_comb begin
    a_d = a_q;
    c_d = c_q; // [RULE24]
    half_carry_d = half_carry_q;
    gie_d = gie_q;
    pend_d = pend_q;
    skip_d = 1'b0;
    err_d = 1'b0;
    pc_d = pc_seq;
    sp_d = stack_pointer_q;
    b_d = b_q;
    x_d = x_q;
    mw0 = '{en: 1'b0, adr: oaddr, dat: 8'h00};
    mw1 = '{en: 1'b0, adr: stack_pointer_q - 8'h01, dat: 8'h00};
    case (cmd_q.op)
      OP_ADD: a_d = {hi5[3:0], lo5[3:0]};
      OP_ADDC, OP_SUBTRACT_WITH_CARRY: begin
        a_d = {hi5[3:0], lo5[3:0]}; // [RULE1] [RULE2]
        c_d = hi5[4];
        half_carry_d = lo5[4];
      end
      OP_AND: a_d = a_q & opnd;
      OP_OR: a_d = a_q | opnd;
      OP_XOR: a_d = a_q ^ opnd;
      OP_AND_SKIP_ZERO: skip_d = (a_q & cmd_q.imm) == 8'h00; // [RULE3]
      OP_COMPARE_EQUAL: skip_d = a_q != opnd; // [RULE5]
      OP_COMPARE_EQUAL_MD: skip_d = dmem_q[cmd_q.addr[DMEM_AW-1:0]] != cmd_q.imm; // [RULE5]
      OP_COMPARE_UNEQUAL: skip_d = a_q == opnd; // [RULE6]
      OP_COMPARE_GREATER: skip_d = !(a_q > opnd); // [RULE4]
      OP_POINTER_NIBBLE_COMPARE: skip_d = b_q[3:0] == cmd_q.imm[3:0]; // [RULE7]
      OP_DECREMENT_SKIP_ZERO: begin
        mw0 = '{en: 1'b1, adr: reg_addr, dat: dec_v}; // [RULE8]
        skip_d = dec_v == 8'h00;
      end
      OP_BIT_SET: mw0 = '{en: 1'b1, adr: oaddr, dat: mem_op | bit_mask}; // [RULE9]
      OP_BIT_CLEAR: mw0 = '{en: 1'b1, adr: oaddr, dat: mem_op & ~bit_mask}; // [RULE9]
      OP_BIT_TEST: begin
        skip_d = ((cmd_q.bit_on_acc ? a_q : mem_op) & bit_mask) == 8'h00; // [RULE10]
      end
      OP_CLEAR_TRAP_PENDING: pend_d = 1'b0; // [RULE11]
      OP_LOAD_ACC: a_d = opnd;
      OP_EXCHANGE_ACC: begin
        a_d = mem_op;
        mw0 = '{en: 1'b1, adr: oaddr, dat: a_q};
      end
      OP_STORE_IMM: mw0 = '{en: 1'b1, adr: oaddr, dat: cmd_q.imm};
      OP_TABLE_LOAD: a_d = tbl_v; // [RULE13]
      OP_DECIMAL_ADJUST: begin
        // Nibbles that produced no carry get six taken off
        a_d = a_q - {c_q ? 4'h0 : `CIS_BCD_ADJ, half_carry_q ? 4'h0 : `CIS_BCD_ADJ}; // [RULE14]
      end
      OP_ROTATE_RIGHT_CARRY: begin
        a_d = {c_q, a_q[7:1]}; // [RULE15]
        c_d = a_q[0];
      end
      OP_ROTATE_LEFT_CARRY: begin
        a_d = {a_q[6:0], c_q}; // [RULE15]
        c_d = a_q[7];
        half_carry_d = a_q[0];
      end
      OP_PUSH: begin
        mw0 = '{en: 1'b1, adr: stack_pointer_q, dat: a_q}; // [RULE16]
        sp_d = stack_pointer_q - 8'h01;
      end
      OP_POP: begin
        sp_d = sp_up1; // [RULE16]
        a_d = dmem_q[sp_up1[DMEM_AW-1:0]];
      end
      OP_VECTOR_DISPATCH: pc_d = {vec_hi[6:0], vec_lo}; // [RULE17]
      OP_LONG_JUMP: pc_d = {cmd_q.addr[6:0], cmd_q.imm}; // [RULE18]
      OP_RELATIVE_JUMP: begin
        if (jp_ok) begin
          pc_d = pc_q + {{7{cmd_q.imm[7]}}, cmd_q.imm}; // [RULE19]
        end else begin
          err_d = 1'b1; // [RULE19]
        end
      end
      OP_SOFTWARE_TRAP: begin
        mw0 = '{en: 1'b1, adr: stack_pointer_q, dat: pc_seq[7:0]}; // [RULE20]
        mw1 = '{en: 1'b1, adr: stack_pointer_q - 8'h01, dat: {1'b0, pc_seq[14:8]}};
        sp_d = stack_pointer_q - 8'h02;
        pc_d = `CIS_TRAP_PC;
        pend_d = 1'b1;
      end
      OP_SUBROUTINE_EXIT, OP_INTERRUPT_EXIT: begin
        sp_d = sp_up2; // [RULE21]
        pc_d = {dmem_q[sp_up1[DMEM_AW-1:0]][6:0], dmem_q[sp_up2[DMEM_AW-1:0]]};
        if (cmd_q.op == OP_INTERRUPT_EXIT) begin
          gie_d = 1'b1; // [RULE22]
        end
      end
      default: pc_d = pc_seq; // [RULE24]
    endcase
    // Pointer steps after the access, which already used the old value
    if ((cmd_q.op == OP_LOAD_ACC || cmd_q.op == OP_EXCHANGE_ACC ||
         cmd_q.op == OP_STORE_IMM) && cmd_q.step != STEP_NONE) begin
      if (cmd_q.src == SRC_PTR_B) begin
        b_d = (cmd_q.step == STEP_DEC) ? b_q - 8'h01 : b_q + 8'h01; // [RULE12]
      end else if (cmd_q.src == SRC_PTR_X) begin
        x_d = (cmd_q.step == STEP_DEC) ? x_q - 8'h01 : x_q + 8'h01; // [RULE12]
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Architectural registers; execution wins over a software write in the same cycle

  logic [31:0] fw;
  assign fw = lane_merge(flags_word, wdat, wb_sel_in);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      a_q <= `CIS_RST_ACC;
    end else if (fire) begin
      a_q <= a_d;
    end else if (wr && hit(wb_adr_in, `CIS_OFF_ACC) && wb_sel_in[0]) begin
      a_q <= wdat[7:0];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      c_q <= 1'b0;
      half_carry_q <= 1'b0;
      gie_q <= 1'b0;
      pend_q <= 1'b0;
    end else if (fire) begin
      c_q <= c_d;
      half_carry_q <= half_carry_d;
      gie_q <= gie_d;
      pend_q <= pend_d;
    end else if (wr && hit(wb_adr_in, `CIS_OFF_FLAGS)) begin
      c_q <= fw[`CIS_FB_CARRY];
      half_carry_q <= fw[`CIS_FB_HALF];
      gie_q <= fw[`CIS_FB_GIE];
      pend_q <= fw[`CIS_FB_PEND];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      skip_q <= 1'b0;
    end else if (fire) begin
      skip_q <= skip_d;
    end else if (skip_fire) begin
      skip_q <= 1'b0; // [RULE23]
    end
  end

  // Sticky: a refused command or bad jump; set wins over the write-one clear
  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      err_q <= 1'b0;
    end else if ((fire && err_d) || (cmd_wr && state_q != ST_IDLE)) begin
      err_q <= 1'b1;
    end else if (wr && hit(wb_adr_in, `CIS_OFF_FLAGS) && wb_sel_in[0] && wdat[`CIS_FB_ERR]) begin
      err_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      pc_q <= `CIS_RST_PC;
    end else if (fire) begin
      pc_q <= pc_d;
    end else if (skip_fire) begin
      pc_q <= pc_seq; // [RULE23]
    end else if (wr && hit(wb_adr_in, `CIS_OFF_PC)) begin
      pc_q <= 15'(lane_merge({17'h0_0000, pc_q}, wdat, wb_sel_in));
    end
  end

  logic [31:0] pw;
  assign pw = lane_merge({8'h00, stack_pointer_q, x_q, b_q}, wdat, wb_sel_in);

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      stack_pointer_q <= `CIS_RST_SP;
      b_q <= `CIS_RST_PTR;
      x_q <= `CIS_RST_PTR;
    end else if (fire) begin
      stack_pointer_q <= sp_d;
      b_q <= b_d;
      x_q <= x_d;
    end else if (wr && hit(wb_adr_in, `CIS_OFF_PTRS)) begin
      b_q <= pw[7:0];
      x_q <= pw[15:8];
      stack_pointer_q <= pw[23:16];
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      daddr_q <= 8'h00;
      paddr_q <= 15'h0000;
      vec_q <= 15'h0000;
    end else if (wr) begin
      if (hit(wb_adr_in, `CIS_OFF_DADDR)) begin
        daddr_q <= 8'(lane_merge({24'h00_0000, daddr_q}, wdat, wb_sel_in));
      end
      if (hit(wb_adr_in, `CIS_OFF_PADDR)) begin
        paddr_q <= 15'(lane_merge({17'h0_0000, paddr_q}, wdat, wb_sel_in));
      end
      if (hit(wb_adr_in, `CIS_OFF_VEC)) begin
        vec_q <= 15'(lane_merge({17'h0_0000, vec_q}, wdat, wb_sel_in));
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Memories; no reset, contents are loaded by software

  always_ff @(posedge clk_in) begin
    if (wr && hit(wb_adr_in, `CIS_OFF_DDATA) && wb_sel_in[0]) begin
      dmem_q[daddr_q[DMEM_AW-1:0]] <= wdat[7:0];
    end
    if (fire && mw0.en) begin
      dmem_q[mw0.adr[DMEM_AW-1:0]] <= mw0.dat;
    end
    if (fire && mw1.en) begin
      dmem_q[mw1.adr[DMEM_AW-1:0]] <= mw1.dat;
    end
  end

  always_ff @(posedge clk_in) begin
    if (wr && hit(wb_adr_in, `CIS_OFF_PDATA) && wb_sel_in[0]) begin
      pmem_q[paddr_q[PMEM_AW-1:0]] <= wdat[7:0];
    end
  end

endmodule

// [hw/cis_cfg.svh]
// Offsets, field positions, reset values and fixed constants of the execution unit
`ifndef CIS_CFG_SVH
`define CIS_CFG_SVH

// Word-aligned byte offsets of the software-visible registers
`define CIS_OFF_CMD 8'h00
`define CIS_OFF_ACC 8'h04
`define CIS_OFF_FLAGS 8'h08
`define CIS_OFF_PTRS 8'h0C
`define CIS_OFF_PC 8'h10
`define CIS_OFF_DADDR 8'h14
`define CIS_OFF_DDATA 8'h18
`define CIS_OFF_PADDR 8'h1C
`define CIS_OFF_PDATA 8'h20
`define CIS_OFF_VEC 8'h24

// Bit positions in the flags register
`define CIS_FB_CARRY 0
`define CIS_FB_HALF 1
`define CIS_FB_GIE 2
`define CIS_FB_PEND 3
`define CIS_FB_SKIP 4
`define CIS_FB_BUSY 5
`define CIS_FB_ERR 6

// Reset values
`define CIS_RST_ACC 8'h00
`define CIS_RST_PC 15'h0000
`define CIS_RST_SP 8'h6F
`define CIS_RST_PTR 8'h00

// Fixed execution constants
`define CIS_TRAP_PC 15'h00FF
`define CIS_JP_MIN 8'hE1
`define CIS_JP_MAX 8'h20
`define CIS_JP_BAD 8'h01
`define CIS_BCD_ADJ 4'h6
`define CIS_REG_PAGE 4'hF

`endif

// [hw/cis_pkg.sv]
// Types shared by the instruction execution unit
package cis_pkg;

  typedef enum logic [5:0] {
    OP_NOP = 6'b000000,
    OP_ADD = 6'b000001,
    OP_ADDC = 6'b000010,
    OP_SUBTRACT_WITH_CARRY = 6'b000011,
    OP_AND = 6'b000100,
    OP_OR = 6'b000101,
    OP_XOR = 6'b000110,
    OP_AND_SKIP_ZERO = 6'b000111,
    OP_COMPARE_EQUAL = 6'b001000,
    OP_COMPARE_EQUAL_MD = 6'b001001,
    OP_COMPARE_UNEQUAL = 6'b001010,
    OP_COMPARE_GREATER = 6'b001011,
    OP_POINTER_NIBBLE_COMPARE = 6'b001100,
    OP_DECREMENT_SKIP_ZERO = 6'b001101,
    OP_BIT_SET = 6'b001110,
    OP_BIT_CLEAR = 6'b001111,
    OP_BIT_TEST = 6'b010000,
    OP_CLEAR_TRAP_PENDING = 6'b010001,
    OP_LOAD_ACC = 6'b010010,
    OP_EXCHANGE_ACC = 6'b010011,
    OP_STORE_IMM = 6'b010100,
    OP_TABLE_LOAD = 6'b010101,
    OP_DECIMAL_ADJUST = 6'b010110,
    OP_ROTATE_RIGHT_CARRY = 6'b010111,
    OP_ROTATE_LEFT_CARRY = 6'b011000,
    OP_PUSH = 6'b011001,
    OP_POP = 6'b011010,
    OP_VECTOR_DISPATCH = 6'b011011,
    OP_LONG_JUMP = 6'b011100,
    OP_RELATIVE_JUMP = 6'b011101,
    OP_SOFTWARE_TRAP = 6'b011110,
    OP_SUBROUTINE_EXIT = 6'b011111,
    OP_INTERRUPT_EXIT = 6'b100000
  } cis_op_t;

  typedef enum logic [1:0] {
    SRC_IMM = 2'b00,
    SRC_DIRECT = 2'b01,
    SRC_PTR_B = 2'b10,
    SRC_PTR_X = 2'b11
  } cis_src_t;

  typedef enum logic [1:0] {
    STEP_NONE = 2'b00,
    STEP_INC = 2'b01,
    STEP_DEC = 2'b10,
    STEP_RSVD = 2'b11
  } cis_step_t;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_EXEC = 2'b01,
    ST_SKIP = 2'b10
  } cis_state_t;

  // Command word as written to the command register
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] imm;
    logic [1:0] nbytes;
    logic bit_on_acc;
    logic [2:0] bit_num;
    cis_step_t step;
    cis_src_t src;
    cis_op_t op;
  } cis_cmd_t;

  // One data-memory write port
  typedef struct packed {
    logic en;
    logic [7:0] adr;
    logic [7:0] dat;
  } cis_mwr_t;

endpackage

// [dv/cis_exec_chk.sv]
// Port-level assertion checker for the instruction execution unit
module cis_exec_chk (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic wb_cyc_in,
  input wire logic wb_stb_in,
  input wire logic wb_we_in,
  input wire logic [7:0] wb_adr_in,
  input wire logic [3:0] wb_sel_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic [31:0] wb_dat_out,
  input wire logic wb_ack_out,
  input wire logic global_irq_enable_out,
  input wire logic trap_pending_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic wr;
  // A write commits where ack is sampled; commands execute one edge later
  assign wr = wb_cyc_in & wb_stb_in & wb_we_in & wb_ack_out;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!reset_n_in);
  ack_resp_a: assert property (wb_cyc_in && wb_stb_in && !wb_ack_out |=> wb_ack_out)
    else $error("ack missing one cycle after request");
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack longer than one cycle");
  read_hold_a: assert property (!wb_stb_in && $past(reset_n_in) |=> $stable(wb_dat_out))
    else $error("read data moved without request");
  trap_rise_a: assert property ($rose(trap_pending_out) |-> $past(wr) || $past(wr, 2))
    else $error("trap pending set without command");
  trap_fall_a: assert property ($fell(trap_pending_out) && $past(reset_n_in)
    |-> $past(wr) || $past(wr, 2)) else $error("trap pending cleared without command");
  gie_rise_a: assert property ($rose(global_irq_enable_out)
    |-> $past(wr) || $past(wr, 2)) else $error("irq enable set without command");
  gie_fall_a: assert property ($fell(global_irq_enable_out) && $past(reset_n_in)
    |-> $past(wr) || $past(wr, 2)) else $error("irq enable cleared without write");
  flags_mirror_a: assert property (wb_ack_out && !wb_we_in && wb_adr_in == 8'h08
    |-> wb_dat_out[3:2] == $past({trap_pending_out, global_irq_enable_out}))
    else $error("status bits differ from flag outputs");
endmodule
bind cis_exec_unit cis_exec_chk i_cis_exec_chk (.clk_in(clk_in), .reset_n_in(reset_n_in),
  .wb_cyc_in(wb_cyc_in), .wb_stb_in(wb_stb_in), .wb_we_in(wb_we_in), .wb_adr_in(wb_adr_in),
  .wb_sel_in(wb_sel_in), .wb_dat_in(wb_dat_in), .wb_dat_out(wb_dat_out),
  .wb_ack_out(wb_ack_out), .global_irq_enable_out(global_irq_enable_out),
  .trap_pending_out(trap_pending_out));

// [dv/tb.sv]
// Self-checking bench for the instruction execution unit
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cis_pkg::*;
  typedef struct packed {
    logic [7:0] a;
    logic [1:0] f;
    logic [31:0] c;
    logic [7:0] ea;
    logic [4:0] ef;
  } cis_row_t;
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] wd = 32'h0000_0000;
  logic [31:0] rdat;
  logic [31:0] r;
  logic ack;
  logic global_irq_enable;
  logic pend;
  int failures = 0;
  int comparisons = 0;
  int cycles = 0;
  cis_row_t rows [18];
  cis_exec_unit i_cis_exec_unit (.clk_in(clk_in), .reset_n_in(reset_n_in), .wb_cyc_in(cyc),
    .wb_stb_in(stb), .wb_we_in(we), .wb_adr_in(adr), .wb_sel_in(sel), .wb_dat_in(wd),
    .wb_dat_out(rdat), .wb_ack_out(ack), .global_irq_enable_out(global_irq_enable), .trap_pending_out(pend));
  initial begin
    forever #12.5 clk_in = ~clk_in;
  end
  // ms packs {opcode byte count, pointer step, operand source}
  function automatic logic [31:0] cm(cis_op_t op, logic [7:0] imm = 8'h00,
    logic [3:0] b = 4'h0, logic [7:0] ad = 8'h00, logic [5:0] ms = 6'h20);
    return {ad, imm, ms[5:4], b, ms[3:0], op};
  endfunction
  task automatic complete_run();
    $display("failures %0d comparisons %0d", failures, comparisons);
    if (failures == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Holds the request until ack is sampled, then releases for at least one cycle
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    sel <= 4'hF;
    do @(posedge clk_in); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0000_0000);
    chk(r, e);
  endtask
  // Leaves the settled status word in r
  task automatic ex(input logic [31:0] c);
    wr(8'h00, c);
    do bus(1'b0, 8'h08, 32'h0000_0000); while (r[5] !== 1'b0);
  endtask
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      complete_run();
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rows = '{
      '{8'h38, 2'b01, cm(OP_ADDC, 8'h29), 8'h62, 5'h02},
      '{8'hFF, 2'b00, cm(OP_ADDC, 8'h01), 8'h00, 5'h03},
      '{8'h50, 2'b01, cm(OP_SUBTRACT_WITH_CARRY, 8'h20), 8'h30, 5'h03},
      '{8'h10, 2'b01, cm(OP_SUBTRACT_WITH_CARRY, 8'h20), 8'hF0, 5'h02},
      '{8'hF0, 2'b00, cm(OP_AND_SKIP_ZERO, 8'h0F), 8'hF0, 5'h10},
      '{8'hF0, 2'b00, cm(OP_AND_SKIP_ZERO, 8'h10), 8'hF0, 5'h00},
      '{8'h80, 2'b00, cm(OP_COMPARE_GREATER, 8'h7F), 8'h80, 5'h00},
      '{8'h7F, 2'b00, cm(OP_COMPARE_GREATER, 8'h7F), 8'h7F, 5'h10},
      '{8'h55, 2'b11, cm(OP_COMPARE_EQUAL, 8'h56), 8'h55, 5'h13},
      '{8'h55, 2'b00, cm(OP_COMPARE_UNEQUAL, 8'h55), 8'h55, 5'h10},
      '{8'h00, 2'b00, cm(OP_POINTER_NIBBLE_COMPARE, 8'h00), 8'h00, 5'h10},
      '{8'h80, 2'b00, cm(OP_BIT_TEST, 8'h00, 4'h8), 8'h80, 5'h10},
      '{8'hCC, 2'b00, cm(OP_DECIMAL_ADJUST), 8'h66, 5'h00},
      '{8'h01, 2'b01, cm(OP_ROTATE_RIGHT_CARRY), 8'h80, 5'h01},
      '{8'h81, 2'b00, cm(OP_ROTATE_LEFT_CARRY), 8'h02, 5'h03},
      '{8'hFF, 2'b11, cm(OP_ADD, 8'h01), 8'h00, 5'h03},
      '{8'hF0, 2'b00, cm(OP_XOR, 8'h3C), 8'hCC, 5'h00},
      '{8'hF0, 2'b01, cm(OP_AND, 8'h3C), 8'h30, 5'h01}
    };
    repeat (4) @(posedge clk_in);
    reset_n_in <= 1'b1;
    wr(8'h0C, 32'h006F_20F0);
    foreach (rows[i]) begin
      wr(8'h04, {24'h00_0000, rows[i].a});
      wr(8'h08, {30'h0000_0000, rows[i].f});
      ex(rows[i].c);
      chk({27'h000_0000, r[4:0]}, {27'h000_0000, rows[i].ef});
      rdc(8'h04, {24'h00_0000, rows[i].ea});
      ex(cm(OP_NOP));
    end
    wr(8'h14, 32'h0000_00F3);
    wr(8'h18, 32'h0000_0001);
    ex(cm(OP_DECREMENT_SKIP_ZERO, 8'h00, 4'h0, 8'h03, 6'h21));
    chk({31'h0000_0000, r[4]}, 32'h0000_0001);
    rdc(8'h18, 32'h0000_0000);
    ex(cm(OP_NOP));
    wr(8'h14, 32'h0000_0040);
    wr(8'h18, 32'h0000_0001);
    ex(cm(OP_BIT_SET, 8'h00, 4'h7, 8'h40, 6'h21));
    rdc(8'h18, 32'h0000_0081);
    ex(cm(OP_BIT_CLEAR, 8'h00, 4'h0, 8'h40, 6'h21));
    rdc(8'h18, 32'h0000_0080);
    ex(cm(OP_COMPARE_EQUAL_MD, 8'h80, 4'h0, 8'h40, 6'h21));
    chk({31'h0000_0000, r[4]}, 32'h0000_0000);
    wr(8'h14, 32'h0000_00F0);
    wr(8'h18, 32'h0000_005A);
    ex(cm(OP_LOAD_ACC, 8'h00, 4'h0, 8'h00, 6'h16));
    rdc(8'h04, 32'h0000_005A);
    ex(cm(OP_STORE_IMM, 8'h77, 4'h0, 8'h00, 6'h2B));
    rdc(8'h0C, 32'h006F_1FF1);
    wr(8'h14, 32'h0000_0020);
    rdc(8'h18, 32'h0000_0077);
    ex(cm(OP_PUSH));
    rdc(8'h0C, 32'h006E_1FF1);
    wr(8'h04, 32'h0000_0000);
    ex(cm(OP_POP));
    rdc(8'h04, 32'h0000_005A);
    rdc(8'h0C, 32'h006F_1FF1);
    for (int k = 0; k < 2; k++) begin
      wr(8'h10, 32'h0000_1234);
      ex(cm(OP_SOFTWARE_TRAP, 8'h00, 4'h0, 8'h00, 6'h10));
      rdc(8'h10, 32'h0000_00FF);
      rdc(8'h0C, 32'h006D_1FF1);
      chk({31'h0000_0000, pend}, 32'h0000_0001);
      wr(8'h14, 32'h0000_006F);
      rdc(8'h18, 32'h0000_0035);
      ex(k == 0 ? cm(OP_SUBROUTINE_EXIT) : cm(OP_INTERRUPT_EXIT));
      rdc(8'h10, 32'h0000_1235);
      rdc(8'h0C, 32'h006F_1FF1);
      chk({31'h0000_0000, global_irq_enable}, k);
      ex(cm(OP_CLEAR_TRAP_PENDING));
      chk({31'h0000_0000, pend}, 32'h0000_0000);
      rdc(8'h10, 32'h0000_1237);
    end
    wr(8'h08, 32'h0000_0000);
    ex(cm(OP_LONG_JUMP, 8'hFF, 4'h0, 8'h7F));
    rdc(8'h10, 32'h0000_7FFF);
    wr(8'h10, 32'h0000_0100);
    ex(cm(OP_RELATIVE_JUMP, 8'h20, 4'h0, 8'h00, 6'h10));
    rdc(8'h10, 32'h0000_0120);
    ex(cm(OP_RELATIVE_JUMP, 8'hE1, 4'h0, 8'h00, 6'h10));
    rdc(8'h10, 32'h0000_0101);
    ex(cm(OP_RELATIVE_JUMP, 8'h01, 4'h0, 8'h00, 6'h10));
    rdc(8'h10, 32'h0000_0102);
    rdc(8'h08, 32'h0000_0040);
    wr(8'h10, 32'h0000_0100);
    wr(8'h1C, 32'h0000_0137);
    wr(8'h20, 32'h0000_00C4);
    wr(8'h04, 32'h0000_0037);
    ex(cm(OP_TABLE_LOAD));
    rdc(8'h04, 32'h0000_00C4);
    wr(8'h1C, 32'h0000_0040);
    wr(8'h20, 32'h0000_0012);
    wr(8'h1C, 32'h0000_0041);
    wr(8'h20, 32'h0000_0034);
    wr(8'h24, 32'h0000_0040);
    ex(cm(OP_VECTOR_DISPATCH));
    rdc(8'h10, 32'h0000_1234);
    wr(8'h10, 32'h0000_0200);
    wr(8'h04, 32'h0000_00F0);
    ex(cm(OP_AND_SKIP_ZERO, 8'h0F));
    ex(cm(OP_ADDC, 8'h01));
    rdc(8'h04, 32'h0000_00F0);
    rdc(8'h10, 32'h0000_0204);
    wr(8'h3C, 32'hFFFF_FFFF);
    rdc(8'h3C, 32'h0000_0000);
    // Mid-run reset of a single edge must restore accumulator, flags, pointers and PC
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    rdc(8'h04, 32'h0000_0000);
    rdc(8'h08, 32'h0000_0000);
    rdc(8'h0C, 32'h006F_0000);
    rdc(8'h10, 32'h0000_0000);
    complete_run();
  end
endmodule
